// file: dtc_pkg.sv
// Register map, field positions, reset values and rate constants for the dual timer/counter
package dtc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register addresses in the special-function space
  localparam logic [7:0] ADDR_CTRL_FLAGS = 8'h88;
  localparam logic [7:0] ADDR_MODE_SEL = 8'h89;
  localparam logic [7:0] ADDR_FIRST_LOW = 8'h8A;
  localparam logic [7:0] ADDR_SECOND_LOW = 8'h8B;
  localparam logic [7:0] ADDR_FIRST_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_SECOND_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_RATE_CTRL = 8'h8E;

  ////////////////////////////////////////////////////////////////////////////////
  // timer_control_flags fields
  localparam int CF_OVF1 = 7;
  localparam int CF_RUN1 = 6;
  localparam int CF_OVF0 = 5;
  localparam int CF_RUN0 = 4;
  localparam int CF_IEB = 3;
  localparam int CF_ITB = 2;
  localparam int CF_IEA = 1;
  localparam int CF_ITA = 0;

  // timer_mode_select fields
  localparam int MS_GATE1 = 7;
  localparam int MS_SRC1 = 6;
  localparam int MS_MODE1_LSB = 4;
  localparam int MS_GATE0 = 3;
  localparam int MS_SRC0 = 2;
  localparam int MS_MODE0_LSB = 0;

  // clock_rate_control fields
  localparam int RC_RATE1 = 4;
  localparam int RC_RATE0 = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] CTRL_FLAGS_RST = 8'h00;
  localparam logic [7:0] MODE_SEL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] RATE_CTRL_RST = 8'h01;
  // Bits 7:6 are reserved and read as zero
  localparam logic [7:0] RATE_CTRL_WMASK = 8'h3F;

  ////////////////////////////////////////////////////////////////////////////////
  // Timer increment periods in core clocks
  localparam int FAST_DIV = 4;
  localparam int SLOW_DIV = 12;

  typedef enum logic [1:0] {
    DTC_MODE_13 = 2'b00,
    DTC_MODE_16 = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_type;

endpackage

// file: dtc_pin_sync.sv
// Two-stage pin synchroniser with falling-edge detection
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_sync
  import dtc_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_level,
  output logic [WIDTH-1:0] pin_fall
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  // Idle-high reset so no false falling edge appears after release
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end
    else
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign pin_level = sync_r;
  assign pin_fall = prev_r & ~sync_r;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_chk
      fall_single_pulse_a: assert property (@(posedge clk) disable iff (reset) // R08
        pin_fall[g] |=> !pin_fall[g])
        else $error("falling edge reported on two cycles");
    end
  endgenerate

endmodule
`default_nettype wire

// file: dtc_rate_divider.sv
// Core clock divider giving one-cycle increment enables every 4 and every 12 clocks
`timescale 1ns/1ps
`default_nettype none
module dtc_rate_divider
  import dtc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  output logic tick_fast,
  output logic tick_slow
);

  logic [3:0] div_r;
  logic [3:0] div_nxt;

  assign div_nxt = (div_r == 4'(SLOW_DIV - 1)) ? 4'h0 : div_r + 4'h1;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      div_r <= 4'h0;
    else
      div_r <= div_nxt;
  end

  // Both enables share one counter so fast ticks stay phase-aligned to slow ticks
  assign tick_fast = (div_r[1:0] == 2'(FAST_DIV - 1)); // R09
  assign tick_slow = (div_r == 4'(SLOW_DIV - 1)); // R09

  slow_tick_period_a: assert property (@(posedge clk) disable iff (reset) // R09
    tick_slow |=> (!tick_slow) [*8] ##1 !tick_slow ##1 !tick_slow ##1 !tick_slow ##1 tick_slow)
    else $error("slow tick period is not 12 clocks");

  fast_tick_period_a: assert property (@(posedge clk) disable iff (reset) // R09
    tick_fast |=> (!tick_fast) [*3] ##1 tick_fast)
    else $error("fast tick period is not 4 clocks");

endmodule
`default_nettype wire

// file: dtc_timer_core.sv
// Dual 16-bit timer/counter with mode control, rate select and external interrupt detectors
//
// Contract
// (R01) Each timer is a 16-bit count in software-accessible low and high byte registers.
// (R02) Mode bits: 00 13-bit, 01 16-bit, 10 auto-reload, 11 split or stopped.
// (R03) 13-bit mode counts low byte bits 0-4 plus the high byte.
// (R04) 13-bit wrap clears the count, sets overflow flag, pulses output one clock.
// (R05) 16-bit mode uses both bytes, wraps after all ones, flags like 13-bit.
// (R06) A timer advances only while running; with gate set its irq pin must be high.
// (R07) Source select picks divided core clock or the external count pin.
// (R08) External counting advances once per synchronised falling edge of the count pin.
// (R09) Default rate is every 12 clocks; rate bit set gives every 4 clocks.
// (R10) Auto-reload: low byte counts, reloads from high byte after all ones.
// (R11) Split: first low byte is an 8-bit counter with normal first-timer controls.
// (R12) Split: first high byte counts divided clocks, run by second run bit, sets second flag.
// (R13) Second timer in mode 3 stops and holds both bytes.
// (R14) While split, second timer runs in modes 0-2 with its gate, source and rate.
// (R15) Overflow flags set on overflow and clear when the core vectors.
// (R16) Run bits are software writable; one enables counting.
// (R17) Irq type bit one means falling-edge detection, zero means low-level.
// (R18) Edge mode flag sets on falling edge, clears on vector or software write.
// (R19) Level mode flag follows the inverted pin; software writes are ignored.
// (R20) First timer rate comes from rate control bit 3.
// (R21) Rate bits are independent and do not affect external counting.
// (R22) Rate bits reset to zero so timers start at the 12-clock rate.
// (R23) A software byte write wins over a same-cycle hardware update.
// (R24) Count and irq pins pass two flip-flops before edge detection or gating.
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_core
  import dtc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic first_timer_vector_ack,
  input wire logic second_timer_vector_ack,
  input wire logic ext_irq_a_vector_ack,
  input wire logic ext_irq_b_vector_ack,
  input wire logic first_count_pin,
  input wire logic second_count_pin,
  input wire logic ext_irq_a_pin_n,
  input wire logic ext_irq_b_pin_n,
  output logic [7:0] sfr_rdata,
  output logic first_overflow_pulse,
  output logic second_overflow_pulse,
  output logic first_timer_overflow_flag,
  output logic second_timer_overflow_flag,
  output logic ext_irq_a_detect,
  output logic ext_irq_b_detect
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] ctrl_r;
  logic [7:0] mode_r;
  logic [7:0] rate_r;
  logic [7:0] tl0_r;
  logic [7:0] th0_r;
  logic [7:0] tl1_r;
  logic [7:0] th1_r;
  logic [7:0] rdata_r;
  logic ovf0_pulse_r;
  logic ovf1_pulse_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and rate ticks

  logic [3:0] pin_level;
  logic [3:0] pin_fall;
  logic tick_fast;
  logic tick_slow;

  dtc_pin_sync #(.WIDTH(4)) u_pin_sync ( // R24
    .clk(clk),
    .reset(reset),
    .pin_in({ext_irq_b_pin_n, ext_irq_a_pin_n, second_count_pin, first_count_pin}),
    .pin_level(pin_level),
    .pin_fall(pin_fall)
  );

  dtc_rate_divider u_rate_divider (
    .clk(clk),
    .reset(reset),
    .tick_fast(tick_fast),
    .tick_slow(tick_slow)
  );

  logic irq_a_level;
  logic irq_b_level;
  assign irq_a_level = pin_level[2];
  assign irq_b_level = pin_level[3];

  ////////////////////////////////////////////////////////////////////////////////
  // Count step: returns {overflow, high, low} after one increment

  function automatic logic [16:0] count_step(input dtc_mode_type mode, input logic [7:0] hi,
                                             input logic [7:0] lo);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0] c8;
    c13 = {1'b0, hi, lo[4:0]} + 14'h0001; // R03
    c16 = {1'b0, hi, lo} + 17'h00001;
    c8 = {1'b0, lo} + 9'h001;
    case (mode) // R02
      DTC_MODE_13: count_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]}; // R03 R04
      DTC_MODE_16: count_step = c16; // R05
      DTC_MODE_RELOAD: count_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])}; // R10
      default: count_step = {c8[8], hi, c8[7:0]}; // R11
    endcase
  endfunction

  // Hardware set wins over software write and vector clear
  function automatic logic flag_next(input logic set, input logic wr, input logic wbit,
                                     input logic ack, input logic cur);
    if (set)
      flag_next = 1'b1;
    else if (wr)
      flag_next = wbit;
    else if (ack)
      flag_next = 1'b0;
    else
      flag_next = cur;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Increment enables

  dtc_mode_type mode0;
  dtc_mode_type mode1;
  logic split;
  logic tick0;
  logic tick1;
  logic inc0;
  logic inc1;
  logic inc_th0;
  logic [16:0] step0;
  logic [16:0] step1;
  logic [8:0] th0_sum;
  logic ovf0;
  logic ovf1;
  logic ovf_th0;

  assign mode0 = dtc_mode_type'(mode_r[MS_MODE0_LSB +: 2]);
  assign mode1 = dtc_mode_type'(mode_r[MS_MODE1_LSB +: 2]);
  assign split = (mode0 == DTC_MODE_SPLIT);
  assign tick0 = rate_r[RC_RATE0] ? tick_fast : tick_slow; // R20 R21
  assign tick1 = rate_r[RC_RATE1] ? tick_fast : tick_slow; // R09 R21

  assign inc0 = ctrl_r[CF_RUN0] & (~mode_r[MS_GATE0] | irq_a_level) // R06 R11
    & (mode_r[MS_SRC0] ? pin_fall[0] : tick0); // R07 R08
  // While split the second timer is switched by its mode instead of its run bit
  assign inc1 = (split | ctrl_r[CF_RUN1]) & (mode1 != DTC_MODE_SPLIT) // R13 R14
    & (~mode_r[MS_GATE1] | irq_b_level) // R06
    & (mode_r[MS_SRC1] ? pin_fall[1] : tick1); // R07 R08
  assign inc_th0 = split & ctrl_r[CF_RUN1] & tick0; // R12

  assign step0 = count_step(mode0, th0_r, tl0_r);
  assign step1 = count_step(mode1, th1_r, tl1_r);
  assign th0_sum = {1'b0, th0_r} + 9'h001;
  assign ovf0 = inc0 & step0[16];
  assign ovf1 = inc1 & step1[16];
  assign ovf_th0 = inc_th0 & th0_sum[8];

  ////////////////////////////////////////////////////////////////////////////////
  // Write decode

  logic wr_ctrl;
  logic wr_mode;
  logic wr_rate;
  logic wr_tl0;
  logic wr_th0;
  logic wr_tl1;
  logic wr_th1;

  assign wr_ctrl = sfr_wr & (sfr_addr == ADDR_CTRL_FLAGS);
  assign wr_mode = sfr_wr & (sfr_addr == ADDR_MODE_SEL);
  assign wr_rate = sfr_wr & (sfr_addr == ADDR_RATE_CTRL);
  assign wr_tl0 = sfr_wr & (sfr_addr == ADDR_FIRST_LOW);
  assign wr_th0 = sfr_wr & (sfr_addr == ADDR_FIRST_HIGH);
  assign wr_tl1 = sfr_wr & (sfr_addr == ADDR_SECOND_LOW);
  assign wr_th1 = sfr_wr & (sfr_addr == ADDR_SECOND_HIGH);

  ////////////////////////////////////////////////////////////////////////////////
  // Count registers

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tl0_r <= COUNT_RST;
      th0_r <= COUNT_RST;
    end
    else
    begin
      if (wr_tl0)
        tl0_r <= sfr_wdata; // R01 R23
      else if (inc0)
        tl0_r <= step0[7:0];
      if (wr_th0)
        th0_r <= sfr_wdata; // R01 R23
      else if (split)
      begin
        if (inc_th0)
          th0_r <= th0_sum[7:0]; // R12
      end
      else if (inc0)
        th0_r <= step0[15:8];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tl1_r <= COUNT_RST;
      th1_r <= COUNT_RST;
    end
    else
    begin
      if (wr_tl1)
        tl1_r <= sfr_wdata; // R01 R23
      else if (inc1)
        tl1_r <= step1[7:0];
      if (wr_th1)
        th1_r <= sfr_wdata; // R01 R23
      else if (inc1)
        th1_r <= step1[15:8];
    end
  end

  // Overflow outputs: the second one keeps tracking the second timer for baud use
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ovf0_pulse_r <= 1'b0;
      ovf1_pulse_r <= 1'b0;
    end
    else
    begin
      ovf0_pulse_r <= ovf0; // R04 R05
      ovf1_pulse_r <= ovf1; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mode_r <= MODE_SEL_RST;
      rate_r <= RATE_CTRL_RST; // R22
    end
    else
    begin
      if (wr_mode)
        mode_r <= sfr_wdata;
      if (wr_rate)
        rate_r <= sfr_wdata & RATE_CTRL_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control and flag register

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ctrl_r <= CTRL_FLAGS_RST;
    else
    begin
      ctrl_r[CF_OVF0] <= flag_next(ovf0, wr_ctrl, sfr_wdata[CF_OVF0], // R15
                                   first_timer_vector_ack, ctrl_r[CF_OVF0]);
      ctrl_r[CF_OVF1] <= flag_next(split ? ovf_th0 : ovf1, wr_ctrl, sfr_wdata[CF_OVF1], // R12 R15
                                   second_timer_vector_ack, ctrl_r[CF_OVF1]);
      if (wr_ctrl)
      begin
        ctrl_r[CF_RUN0] <= sfr_wdata[CF_RUN0]; // R16
        ctrl_r[CF_RUN1] <= sfr_wdata[CF_RUN1]; // R16
        ctrl_r[CF_ITA] <= sfr_wdata[CF_ITA]; // R17
        ctrl_r[CF_ITB] <= sfr_wdata[CF_ITB]; // R17
      end
      if (!ctrl_r[CF_ITA])
        ctrl_r[CF_IEA] <= ~irq_a_level; // R19
      else
        ctrl_r[CF_IEA] <= flag_next(pin_fall[2], wr_ctrl, sfr_wdata[CF_IEA], // R18
                                    ext_irq_a_vector_ack, ctrl_r[CF_IEA]);
      if (!ctrl_r[CF_ITB])
        ctrl_r[CF_IEB] <= ~irq_b_level; // R19
      else
        ctrl_r[CF_IEB] <= flag_next(pin_fall[3], wr_ctrl, sfr_wdata[CF_IEB], // R18
                                    ext_irq_b_vector_ack, ctrl_r[CF_IEB]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port: data appears the cycle after the read strobe

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata_r <= 8'h00;
    else if (sfr_rd)
    begin
      case (sfr_addr)
        ADDR_CTRL_FLAGS: rdata_r <= ctrl_r;
        ADDR_MODE_SEL: rdata_r <= mode_r;
        ADDR_RATE_CTRL: rdata_r <= rate_r;
        ADDR_FIRST_LOW: rdata_r <= tl0_r; // R01
        ADDR_FIRST_HIGH: rdata_r <= th0_r; // R01
        ADDR_SECOND_LOW: rdata_r <= tl1_r; // R01
        ADDR_SECOND_HIGH: rdata_r <= th1_r; // R01
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata = rdata_r;
  assign first_overflow_pulse = ovf0_pulse_r;
  assign second_overflow_pulse = ovf1_pulse_r;
  assign first_timer_overflow_flag = ctrl_r[CF_OVF0];
  assign second_timer_overflow_flag = ctrl_r[CF_OVF1];
  assign ext_irq_a_detect = ctrl_r[CF_IEA];
  assign ext_irq_b_detect = ctrl_r[CF_IEB];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence wrap13_seq;
    inc0 && mode0 == DTC_MODE_13 && {th0_r, tl0_r[4:0]} == 13'h1FFF && !wr_tl0 && !wr_th0;
  endsequence

  sequence wrap13_result_seq;
    tl0_r[4:0] == 5'h00 && th0_r == 8'h00 && first_timer_overflow_flag && first_overflow_pulse
      ##1 !first_overflow_pulse;
  endsequence

  wrap13_rollover_a: assert property (wrap13_seq |=> wrap13_result_seq) // R03 R04
    else $error("13-bit wrap did not clear count, set flag and pulse once");

  wrap16_rollover_a: assert property (inc0 && mode0 == DTC_MODE_16 && {th0_r, tl0_r} == 16'hFFFF // R05
    && !wr_tl0 && !wr_th0 |=> {th0_r, tl0_r} == 16'h0000 && first_overflow_pulse)
    else $error("16-bit wrap wrong");

  reload_value_a: assert property (inc1 && mode1 == DTC_MODE_RELOAD && tl1_r == 8'hFF // R10
    && !wr_tl1 && !wr_th1 |=> tl1_r == $past(th1_r) && second_overflow_pulse)
    else $error("auto-reload did not load high byte");

  stopped_hold_a: assert property (mode1 == DTC_MODE_SPLIT && !wr_tl1 && !wr_th1 // R13
    |=> $stable(tl1_r) && $stable(th1_r))
    else $error("second timer changed in mode 3");

  run_off_hold_a: assert property (!ctrl_r[CF_RUN0] && !split && !wr_tl0 && !wr_th0 // R06 R16
    |=> $stable(tl0_r) && $stable(th0_r))
    else $error("first timer advanced while stopped");

  gate_block_a: assert property (mode_r[MS_GATE0] && !irq_a_level |-> !inc0) // R06
    else $error("first timer counted while gated off");

  write_wins_a: assert property (wr_tl0 |=> tl0_r == $past(sfr_wdata)) // R23
    else $error("low byte write lost to hardware update");

  split_high_flag_a: assert property (split && ovf_th0 |=> second_timer_overflow_flag) // R12
    else $error("split high byte overflow did not set second flag");

  level_track_a: assert property (!ctrl_r[CF_ITA] |=> ext_irq_a_detect == !$past(irq_a_level)) // R19
    else $error("level-mode detect does not follow pin");

  edge_set_a: assert property (ctrl_r[CF_ITA] && pin_fall[2] |=> ext_irq_a_detect) // R18
    else $error("falling edge did not set detect flag");

  flag_set_wins_a: assert property (ovf0 && first_timer_vector_ack |=> first_timer_overflow_flag) // R15
    else $error("overflow lost against vector clear");

endmodule
`default_nettype wire

// file: dtc_core_model.sv
// Processor-core side model: register writes, reads and interrupt vector acknowledges
`timescale 1ns/1ps
`default_nettype none
module dtc_core_model
(
  input wire logic clk,
  input wire logic [7:0] sfr_rdata,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic [7:0] sfr_wdata,
  output logic sfr_rd,
  output logic [3:0] ack
);
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    sfr_rd = 1'b0;
    ack = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strobes stand for one edge; released lines show inverted junk, not the old value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
    sfr_addr = ~a;
    sfr_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk);
    #1;
    sfr_rd = 1'b0;
    sfr_addr = ~a;
    d = sfr_rdata;
  endtask

  // Index 0 first timer, 1 second timer, 2 irq a, 3 irq b
  task automatic vec(input int k);
    @(posedge clk);
    #1;
    ack[k] = 1'b1;
    @(posedge clk);
    #1;
    ack = 4'h0;
  endtask
endmodule
`default_nettype wire

// file: dual_timer_counter_modes_test.sv
// Self-checking bench for the dual timer/counter block
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_modes_test;
  import dtc_pkg::*;
  typedef struct packed { logic [7:0] mode, lo, hi, mask, exp_lo, exp_hi; } dtc_row_type;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cnt_a = 1'b1;
  logic cnt_b = 1'b1;
  logic irq_a_n = 1'b1;
  logic irq_b_n = 1'b1;
  wire logic [7:0] sfr_addr;
  wire logic [7:0] sfr_wdata;
  wire logic [7:0] sfr_rdata;
  wire logic sfr_wr;
  wire logic sfr_rd;
  wire logic [3:0] ack;
  wire logic pulse0;
  wire logic pulse1;
  wire logic flag0;
  wire logic flag1;
  wire logic det_a;
  wire logic det_b;
  int mismatches = 0;
  int n_compared = 0;
  logic [7:0] d;
  int n;
  // Preset one below wrap so the first increment overflows
  dtc_row_type rows [3] = '{
    '{8'h00, 8'hFF, 8'hFF, 8'h1F, 8'h00, 8'h00},
    '{8'h01, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00},
    '{8'h02, 8'hFF, 8'h77, 8'hFF, 8'h77, 8'h77}
  };

  always #10 clk = ~clk;

  dtc_core_model core (.clk(clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .ack(ack));

  dtc_timer_core dut (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .first_timer_vector_ack(ack[0]),
    .second_timer_vector_ack(ack[1]), .ext_irq_a_vector_ack(ack[2]), .ext_irq_b_vector_ack(ack[3]),
    .first_count_pin(cnt_a), .second_count_pin(cnt_b), .ext_irq_a_pin_n(irq_a_n),
    .ext_irq_b_pin_n(irq_b_n), .sfr_rdata(sfr_rdata), .first_overflow_pulse(pulse0),
    .second_overflow_pulse(pulse1), .first_timer_overflow_flag(flag0),
    .second_timer_overflow_flag(flag1), .ext_irq_a_detect(det_a), .ext_irq_b_detect(det_b));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic sel(input int k);
    case (k)
      0: return pulse0;
      1: return pulse1;
      2: return flag1;
      default: return det_a;
    endcase
  endfunction

  // Returns the cycle count to the event, 0 when it never came
  task automatic wait_for(input int k, input int lim, output int c);
    c = 0;
    while (c < lim)
    begin
      @(posedge clk);
      #1;
      c++;
      if (sel(k) === 1'b1)
        return;
    end
    c = 0;
  endtask

  task automatic must(input int k, input int lim);
    int c;
    wait_for(k, lim, c);
    if (c == 0)
    begin
      mismatches++;
      close_out();
    end
  endtask

  // Two idle edges first so a pulse launched before the write cannot be mistaken
  task automatic none(input int k);
    int c;
    repeat (2) @(posedge clk);
    #1;
    wait_for(k, 30, c);
    chk(8'(c), 8'h00);
  endtask

  task automatic gap(input int k, input int exp);
    int c;
    must(k, 40);
    wait_for(k, 40, c);
    chk(8'(c), 8'(exp));
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    foreach (rows[i])
    begin
      core.wr(ADDR_CTRL_FLAGS, 8'h00);
      core.wr(ADDR_MODE_SEL, rows[i].mode);
      core.wr(ADDR_FIRST_LOW, rows[i].lo);
      core.wr(ADDR_FIRST_HIGH, rows[i].hi);
      core.wr(ADDR_CTRL_FLAGS, 8'h10);
      must(0, 40);
      chk({7'h00, flag0}, 8'h01);
      wait_for(0, 1, n);
      chk(8'(n), 8'h00);
      core.rd(ADDR_FIRST_LOW, d);
      chk(d & rows[i].mask, rows[i].exp_lo);
      core.rd(ADDR_FIRST_HIGH, d);
      chk(d, rows[i].exp_hi);
      core.vec(0);
      chk({7'h00, flag0}, 8'h00);
    end
    // Reload of all ones makes every increment an overflow, so pulse spacing is the rate
    core.wr(ADDR_CTRL_FLAGS, 8'h00);
    core.wr(ADDR_MODE_SEL, 8'h22);
    core.wr(ADDR_FIRST_LOW, 8'hFF);
    core.wr(ADDR_FIRST_HIGH, 8'hFF);
    core.wr(ADDR_SECOND_LOW, 8'hFF);
    core.wr(ADDR_SECOND_HIGH, 8'hFF);
    core.wr(ADDR_CTRL_FLAGS, 8'h50);
    gap(0, SLOW_DIV);
    core.wr(ADDR_RATE_CTRL, 8'h08);
    gap(0, FAST_DIV);
    // Three-cycle spacing walks the vector clear across every phase of the 4-clock overflow
    repeat (4)
    begin
      core.vec(0);
      @(posedge clk);
    end
    gap(1, SLOW_DIV);
    core.wr(ADDR_RATE_CTRL, 8'h10);
    gap(0, SLOW_DIV);
    gap(1, FAST_DIV);
    core.wr(ADDR_CTRL_FLAGS, 8'h40);
    none(0);
    irq_a_n = 1'b0;
    core.wr(ADDR_MODE_SEL, 8'h2A);
    core.wr(ADDR_CTRL_FLAGS, 8'h50);
    none(0);
    irq_a_n = 1'b1;
    must(0, 40);
    core.wr(ADDR_CTRL_FLAGS, 8'h40);
    core.wr(ADDR_MODE_SEL, 8'h55);
    core.wr(ADDR_FIRST_LOW, 8'h00);
    core.wr(ADDR_FIRST_HIGH, 8'hFE);
    core.wr(ADDR_SECOND_LOW, 8'h00);
    core.wr(ADDR_CTRL_FLAGS, 8'h50);
    repeat (3)
    begin
      cnt_a = 1'b0;
      cnt_b = 1'b0;
      settle();
      cnt_a = 1'b1;
      cnt_b = 1'b1;
      settle();
    end
    core.rd(ADDR_FIRST_LOW, d);
    chk(d, 8'h03);
    core.rd(ADDR_SECOND_LOW, d);
    chk(d, 8'h03);
    core.wr(ADDR_CTRL_FLAGS, 8'h00);
    core.wr(ADDR_FIRST_LOW, 8'hFF);
    core.wr(ADDR_SECOND_LOW, 8'hFF);
    core.wr(ADDR_MODE_SEL, 8'h23);
    none(2);
    must(1, 40);
    core.wr(ADDR_CTRL_FLAGS, 8'h50);
    must(0, 40);
    must(2, 40);
    core.vec(1);
    chk({7'h00, flag1}, 8'h00);
    core.wr(ADDR_MODE_SEL, 8'h33);
    none(1);
    core.wr(ADDR_CTRL_FLAGS, 8'h01);
    irq_a_n = 1'b0;
    must(3, 6);
    core.vec(2);
    chk({7'h00, det_a}, 8'h00);
    irq_a_n = 1'b1;
    settle();
    irq_a_n = 1'b0;
    must(3, 6);
    core.wr(ADDR_CTRL_FLAGS, 8'h01);
    chk({7'h00, det_a}, 8'h00);
    irq_a_n = 1'b1;
    irq_b_n = 1'b0;
    core.wr(ADDR_CTRL_FLAGS, 8'h00);
    settle();
    chk({7'h00, det_b}, 8'h01);
    irq_b_n = 1'b1;
    settle();
    chk({7'h00, det_b}, 8'h00);
    core.wr(ADDR_CTRL_FLAGS, 8'h04);
    irq_b_n = 1'b0;
    settle();
    chk({7'h00, det_b}, 8'h01);
    core.vec(3);
    chk({7'h00, det_b}, 8'h00);
    irq_b_n = 1'b1;
    core.wr(ADDR_CTRL_FLAGS, 8'h0A);
    core.rd(ADDR_CTRL_FLAGS, d);
    chk(d, 8'h00);
    core.wr(ADDR_SECOND_LOW, 8'hA5);
    core.wr(ADDR_SECOND_HIGH, 8'h5A);
    core.wr(ADDR_RATE_CTRL, 8'hFF);
    core.wr(8'h90, 8'h3C);
    core.rd(ADDR_SECOND_LOW, d);
    chk(d, 8'hA5);
    core.rd(ADDR_SECOND_HIGH, d);
    chk(d, 8'h5A);
    core.rd(ADDR_RATE_CTRL, d);
    chk(d, RATE_CTRL_WMASK);
    core.rd(8'h90, d);
    chk(d, 8'h00);
    // Reset in mid-run must bring every register back
    reset = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    for (int a = 8'h88; a <= 8'h8E; a++)
    begin
      core.rd(8'(a), d);
      chk(d, (a == 8'h8E) ? RATE_CTRL_RST : 8'h00);
    end
    close_out();
  end
endmodule
`default_nettype wire
